// ==== core/cursor_pkg.sv ====
// shared constants for the waveform cursor control block
package cursor_pkg;

  // ----------------------------------------------------------------
  // waveform record geometry
  // ----------------------------------------------------------------
  localparam int unsigned PT_W = 9;
  localparam logic [PT_W-1:0] FIRST_POINT = 9'h000;
  localparam logic [PT_W-1:0] LAST_POINT = 9'h1FF;
  // graticule right edge coincides with the last stored point
  localparam logic [PT_W-1:0] GRAT_RIGHT = LAST_POINT;
  localparam int unsigned SAMPLE_W = 10;
  localparam int unsigned COORD_W = SAMPLE_W + 1;

  // ----------------------------------------------------------------
  // readout placement
  // ----------------------------------------------------------------
  localparam logic [3:0] READOUT_ROW = 4'hF;
  localparam logic [3:0] ROW_BLANK = 4'h0;

  // ----------------------------------------------------------------
  // keypad bit positions
  // ----------------------------------------------------------------
  localparam int unsigned KEY_N = 10;
  localparam int unsigned K_C1_RIGHT = 0;
  localparam int unsigned K_C1_LEFT = 1;
  localparam int unsigned K_C2_RIGHT = 2;
  localparam int unsigned K_C2_LEFT = 3;
  localparam int unsigned K_C1_ON = 4;
  localparam int unsigned K_DUAL = 5;
  localparam int unsigned K_OFF = 6;
  localparam int unsigned K_GROUND = 7;
  localparam int unsigned K_AMP = 8;
  localparam int unsigned K_TIME = 9;

  // ----------------------------------------------------------------
  // cursor modes and measurement kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CRS_OFF = 3'b001,
    CRS_ONE = 3'b010,
    CRS_TWO = 3'b100
  } crs_mode_e;

  localparam logic MEAS_AMPLITUDE = 1'b0;
  localparam logic MEAS_TIME = 1'b1;

  // ----------------------------------------------------------------
  // key hold timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HOLD_DELAY_MS = 400;
  localparam int unsigned REPEAT_START_MS = 100;
  localparam int unsigned REPEAT_MIN_MS = 10;
  localparam int unsigned HOLD_CYCLES = HOLD_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned REPEAT_START_CYCLES = REPEAT_START_MS * (CLK_HZ / 1000);
  localparam int unsigned REPEAT_MIN_CYCLES = REPEAT_MIN_MS * (CLK_HZ / 1000);
  // each repeat shortens the interval by one part in two to the ACCEL_SHIFT
  localparam int unsigned ACCEL_SHIFT = 3;

endpackage : cursor_pkg

// ==== core/key_repeat.sv ====
// one positioning key: single step on press, accelerating repeat on hold
`timescale 1ns/1ps
`default_nettype none

module key_repeat
#(
  parameter int unsigned HOLD_CYCLES = cursor_pkg::HOLD_CYCLES,
  parameter int unsigned START_CYCLES = cursor_pkg::REPEAT_START_CYCLES,
  parameter int unsigned MIN_CYCLES = cursor_pkg::REPEAT_MIN_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // synchronised key level and step pulse
  input wire logic key_i,
  output logic step_o
);
  import cursor_pkg::*;

  logic held_r;
  logic [31:0] count_r;
  logic [31:0] interval_r;
  logic [31:0] shorter;

  always_comb
  begin
    // at least one cycle off, so short intervals still speed up
    shorter = interval_r - ((interval_r >> ACCEL_SHIFT) | 32'h1);
  end

  // ----------------------------------------------------------------
  // step and repeat timing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      held_r <= 1'b0;
      count_r <= 32'h0;
      interval_r <= 32'h0;
      step_o <= 1'b0;
    end
    else if (!key_i)
    begin
      held_r <= 1'b0;
      count_r <= 32'h0;
      step_o <= 1'b0;
    end
    else if (!held_r)
    begin
      held_r <= 1'b1;
      step_o <= 1'b1;
      count_r <= 32'(HOLD_CYCLES - 1);
      interval_r <= 32'(START_CYCLES);
    end
    else if (count_r == 32'h0)
    begin
      step_o <= 1'b1;
      count_r <= interval_r - 32'h1;
      interval_r <= (shorter > 32'(MIN_CYCLES)) ? shorter : 32'(MIN_CYCLES);
    end
    else
    begin
      step_o <= 1'b0;
      count_r <= count_r - 32'h1;
    end
  end

endmodule : key_repeat

`default_nettype wire

// ==== core/waveform_cursor_control.sv ====
// two-cursor positioning, readout and measurement span for a stored waveform
//
// Contract
// - first cursor starts leftmost, else last position
// - coordinates shown on row 15 when active
// - first cursor right; warn at last point
// - first cursor left; warn at first point
// - first press moves exactly one point
// - held key repeats, speeding up over time
// - release stops motion immediately
// - dual key: second cursor, delta readout
// - second never before first; warn, zero delta
// - second cursor right; warn at graticule edge
// - off keeps positions for later reactivation
// - first cursor pushes second cursor along
// - measurements use cursor status and positions
// - ground key captures trace level reference
// - single cursor absolute readout; none blank
// - span: all, first-to-end, or between cursors
`timescale 1ns/1ps
`default_nettype none

module waveform_cursor_control
#(
  parameter int unsigned HOLD_CYCLES = cursor_pkg::HOLD_CYCLES,
  parameter int unsigned START_CYCLES = cursor_pkg::REPEAT_START_CYCLES,
  parameter int unsigned MIN_CYCLES = cursor_pkg::REPEAT_MIN_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // keypad pins, active high levels
  input wire logic first_cursor_step_right_i,
  input wire logic first_cursor_step_left_i,
  input wire logic second_cursor_step_right_i,
  input wire logic second_cursor_step_left_i,
  input wire logic first_cursor_enable_i,
  input wire logic dual_cursor_enable_i,
  input wire logic cursors_off_i,
  input wire logic ground_set_i,
  input wire logic amplitude_measure_i,
  input wire logic time_measure_i,
  // stored waveform access
  output logic [cursor_pkg::PT_W-1:0] sample_addr_o,
  input wire logic signed [cursor_pkg::SAMPLE_W-1:0] sample_data_i,
  input wire logic signed [cursor_pkg::SAMPLE_W-1:0] vertical_zero_reference_i,
  input wire logic signed [cursor_pkg::SAMPLE_W-1:0] trace_level_i,
  // cursor state
  output logic [cursor_pkg::PT_W-1:0] first_cursor_pos_o,
  output logic [cursor_pkg::PT_W-1:0] second_cursor_pos_o,
  output logic first_cursor_on_o,
  output logic second_cursor_on_o,
  output logic cursor_limit_warning_o,
  // readout
  output logic [3:0] readout_row_o,
  output logic readout_delta_o,
  output logic signed [cursor_pkg::COORD_W-1:0] vertical_cursor_coordinate_o,
  output logic [cursor_pkg::PT_W-1:0] horizontal_cursor_coordinate_o,
  // measurement request
  output logic measure_start_o,
  output logic measure_kind_o,
  output logic [cursor_pkg::PT_W-1:0] span_first_o,
  output logic [cursor_pkg::PT_W-1:0] span_last_o,
  output logic signed [cursor_pkg::SAMPLE_W-1:0] ground_ref_o
);
  import cursor_pkg::*;

  // ----------------------------------------------------------------
  // keypad synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [KEY_N-1:0] keys_pin;
  logic [KEY_N-1:0] keys_meta_r;
  logic [KEY_N-1:0] keys_sync_r;
  logic [KEY_N-1:0] keys_prev_r;
  logic [KEY_N-1:0] keys_rise;

  always_comb
  begin
    keys_pin = '0;
    keys_pin[K_C1_RIGHT] = first_cursor_step_right_i;
    keys_pin[K_C1_LEFT] = first_cursor_step_left_i;
    keys_pin[K_C2_RIGHT] = second_cursor_step_right_i;
    keys_pin[K_C2_LEFT] = second_cursor_step_left_i;
    keys_pin[K_C1_ON] = first_cursor_enable_i;
    keys_pin[K_DUAL] = dual_cursor_enable_i;
    keys_pin[K_OFF] = cursors_off_i;
    keys_pin[K_GROUND] = ground_set_i;
    keys_pin[K_AMP] = amplitude_measure_i;
    keys_pin[K_TIME] = time_measure_i;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      keys_meta_r <= '0;
      keys_sync_r <= '0;
      keys_prev_r <= '0;
    end
    else
    begin
      keys_meta_r <= keys_pin;
      keys_sync_r <= keys_meta_r;
      keys_prev_r <= keys_sync_r;
    end
  end

  assign keys_rise = keys_sync_r & ~keys_prev_r;

  // ----------------------------------------------------------------
  // step generators, one per positioning key
  // ----------------------------------------------------------------
  logic step_c1_right;
  logic step_c1_left;
  logic step_c2_right;
  logic step_c2_left;

  key_repeat #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .START_CYCLES(START_CYCLES),
    .MIN_CYCLES(MIN_CYCLES)
  ) u_rep_c1_right (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .key_i(keys_sync_r[K_C1_RIGHT]),
    .step_o(step_c1_right)
  );

  key_repeat #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .START_CYCLES(START_CYCLES),
    .MIN_CYCLES(MIN_CYCLES)
  ) u_rep_c1_left (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .key_i(keys_sync_r[K_C1_LEFT]),
    .step_o(step_c1_left)
  );

  key_repeat #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .START_CYCLES(START_CYCLES),
    .MIN_CYCLES(MIN_CYCLES)
  ) u_rep_c2_right (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .key_i(keys_sync_r[K_C2_RIGHT]),
    .step_o(step_c2_right)
  );

  key_repeat #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .START_CYCLES(START_CYCLES),
    .MIN_CYCLES(MIN_CYCLES)
  ) u_rep_c2_left (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .key_i(keys_sync_r[K_C2_LEFT]),
    .step_o(step_c2_left)
  );

  // ----------------------------------------------------------------
  // cursor mode
  // ----------------------------------------------------------------
  crs_mode_e mode_r;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      mode_r <= CRS_OFF;
    else if (keys_rise[K_OFF])
      mode_r <= CRS_OFF;
    else if (keys_rise[K_DUAL])
      mode_r <= CRS_TWO;
    else if (keys_rise[K_C1_ON] && mode_r == CRS_OFF)
      mode_r <= CRS_ONE;
  end

  // ----------------------------------------------------------------
  // cursor positions, one step applied per cycle
  // ----------------------------------------------------------------
  logic [PT_W-1:0] c1_r;
  logic [PT_W-1:0] c2_r;
  logic [PT_W-1:0] c1_nxt;
  logic [PT_W-1:0] c2_nxt;
  logic warn_nxt;
  logic c1_act;
  logic c2_act;

  assign c1_act = (mode_r != CRS_OFF);
  assign c2_act = (mode_r == CRS_TWO);

  always_comb
  begin
    c1_nxt = c1_r;
    c2_nxt = c2_r;
    warn_nxt = 1'b0;
    if (c1_act && step_c1_right)
    begin
      if (c1_r != LAST_POINT)
        c1_nxt = c1_r + 9'h001;
      warn_nxt = (c1_nxt == LAST_POINT);
      if (c2_r < c1_nxt)
        c2_nxt = c1_nxt;
    end
    else if (c1_act && step_c1_left)
    begin
      if (c1_r != FIRST_POINT)
        c1_nxt = c1_r - 9'h001;
      warn_nxt = (c1_nxt == FIRST_POINT);
    end
    else if (c2_act && step_c2_right)
    begin
      if (c2_r != GRAT_RIGHT)
        c2_nxt = c2_r + 9'h001;
      warn_nxt = (c2_nxt == GRAT_RIGHT);
    end
    else if (c2_act && step_c2_left)
    begin
      if (c2_r > c1_r)
        c2_nxt = c2_r - 9'h001;
      warn_nxt = (c2_nxt == c1_r);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      c1_r <= FIRST_POINT;
      c2_r <= FIRST_POINT;
      cursor_limit_warning_o <= 1'b0;
    end
    else
    begin
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
      cursor_limit_warning_o <= warn_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      first_cursor_pos_o <= FIRST_POINT;
      second_cursor_pos_o <= FIRST_POINT;
      first_cursor_on_o <= 1'b0;
      second_cursor_on_o <= 1'b0;
    end
    else
    begin
      first_cursor_pos_o <= c1_nxt;
      second_cursor_pos_o <= c2_nxt;
      first_cursor_on_o <= c1_act;
      second_cursor_on_o <= c2_act;
    end
  end

  // ----------------------------------------------------------------
  // cursor sample fetch, alternating between the two cursors
  // ----------------------------------------------------------------
  logic fetch_sel_r;
  logic fetch_sel_d_r;
  logic signed [SAMPLE_W-1:0] lvl1_r;
  logic signed [SAMPLE_W-1:0] lvl2_r;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fetch_sel_r <= 1'b0;
      fetch_sel_d_r <= 1'b0;
      sample_addr_o <= FIRST_POINT;
      lvl1_r <= '0;
      lvl2_r <= '0;
    end
    else
    begin
      fetch_sel_r <= ~fetch_sel_r;
      fetch_sel_d_r <= fetch_sel_r;
      sample_addr_o <= fetch_sel_r ? c2_r : c1_r;
      if (fetch_sel_d_r)
        lvl2_r <= sample_data_i;
      else
        lvl1_r <= sample_data_i;
    end
  end

  // ----------------------------------------------------------------
  // coordinate readout
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      readout_row_o <= ROW_BLANK;
      readout_delta_o <= 1'b0;
      vertical_cursor_coordinate_o <= '0;
      horizontal_cursor_coordinate_o <= FIRST_POINT;
    end
    else
    begin
      case (mode_r)
        CRS_ONE:
        begin
          readout_row_o <= READOUT_ROW;
          readout_delta_o <= 1'b0;
          vertical_cursor_coordinate_o <= COORD_W'(lvl1_r) - COORD_W'(vertical_zero_reference_i);
          horizontal_cursor_coordinate_o <= c1_r;
        end
        CRS_TWO:
        begin
          readout_row_o <= READOUT_ROW;
          readout_delta_o <= 1'b1;
          vertical_cursor_coordinate_o <= COORD_W'(lvl2_r) - COORD_W'(lvl1_r);
          horizontal_cursor_coordinate_o <= c2_r - c1_r;
        end
        default:
        begin
          readout_row_o <= ROW_BLANK;
          readout_delta_o <= 1'b0;
          vertical_cursor_coordinate_o <= '0;
          horizontal_cursor_coordinate_o <= FIRST_POINT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ground reference
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ground_ref_o <= '0;
    else if (keys_rise[K_GROUND])
      ground_ref_o <= trace_level_i;
  end

  // ----------------------------------------------------------------
  // measurement request with cursor span
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      measure_start_o <= 1'b0;
      measure_kind_o <= MEAS_AMPLITUDE;
      span_first_o <= FIRST_POINT;
      span_last_o <= LAST_POINT;
    end
    else if (keys_rise[K_AMP] || keys_rise[K_TIME])
    begin
      measure_start_o <= 1'b1;
      measure_kind_o <= keys_rise[K_AMP] ? MEAS_AMPLITUDE : MEAS_TIME;
      case (mode_r)
        CRS_ONE:
        begin
          span_first_o <= c1_r;
          span_last_o <= LAST_POINT;
        end
        CRS_TWO:
        begin
          span_first_o <= c1_r;
          span_last_o <= c2_r;
        end
        default:
        begin
          span_first_o <= FIRST_POINT;
          span_last_o <= LAST_POINT;
        end
      endcase
    end
    else
      measure_start_o <= 1'b0;
  end

endmodule : waveform_cursor_control

`default_nettype wire

// ==== verif/keypad_model.sv ====
// operator at the cursor keypad: presses and holds keys
`timescale 1ns/1ps
`default_nettype none

module keypad_model
(
  // clock
  input wire logic clk_i,
  // key levels, high while pressed
  output logic [cursor_pkg::KEY_N-1:0] keys_o
);
  import cursor_pkg::*;
  // ----------------------------------------
  // key presses, changed just after an edge
  // ----------------------------------------
  initial keys_o = '0;

  task automatic press(input int k, input int n);
    @(posedge clk_i);
    #1 keys_o[k] = 1'b1;
    repeat (n) @(posedge clk_i);
    #1 keys_o[k] = 1'b0;
  endtask : press
endmodule : keypad_model

`default_nettype wire

// ==== verif/waveform_cursor_control_sva.sv ====
// port assertions for the waveform cursor control block
`timescale 1ns/1ps
`default_nettype none

module waveform_cursor_control_sva
#(
  parameter int unsigned HOLD_CYCLES = 20,
  parameter int unsigned START_CYCLES = 8,
  parameter int unsigned MIN_CYCLES = 2
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched outputs
  input wire logic [cursor_pkg::PT_W-1:0] first_cursor_pos_o,
  input wire logic [cursor_pkg::PT_W-1:0] second_cursor_pos_o,
  input wire logic first_cursor_on_o,
  input wire logic second_cursor_on_o,
  input wire logic cursor_limit_warning_o,
  input wire logic [3:0] readout_row_o,
  input wire logic readout_delta_o,
  input wire logic [cursor_pkg::PT_W-1:0] horizontal_cursor_coordinate_o,
  input wire logic measure_start_o,
  input wire logic [cursor_pkg::PT_W-1:0] span_first_o,
  input wire logic [cursor_pkg::PT_W-1:0] span_last_o
);
  import cursor_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // positions, warning, readout, span
  // ----------------------------------------
  a_order_kept: assert property (second_cursor_on_o
    |-> second_cursor_pos_o >= first_cursor_pos_o)
    else $error("second cursor before first");
  a_single_step: assert property ($changed(first_cursor_pos_o)
    |-> first_cursor_pos_o == $past(first_cursor_pos_o) + 9'h001
    || first_cursor_pos_o == $past(first_cursor_pos_o) - 9'h001)
    else $error("first cursor jumped");
  a_warn_limit: assert property (cursor_limit_warning_o
    |-> first_cursor_pos_o == FIRST_POINT || first_cursor_pos_o == LAST_POINT
    || second_cursor_pos_o == GRAT_RIGHT || second_cursor_pos_o == first_cursor_pos_o)
    else $error("warning away from a limit");
  a_idle_frozen: assert property (!first_cursor_on_o && !second_cursor_on_o
    |-> $stable(first_cursor_pos_o) && $stable(second_cursor_pos_o))
    else $error("cursor moved while off");
  a_row_active: assert property (first_cursor_on_o
    |-> readout_row_o == READOUT_ROW)
    else $error("readout row wrong while active");
  a_blank_off: assert property ((!first_cursor_on_o && !second_cursor_on_o)[*4]
    |-> $past(readout_row_o) == ROW_BLANK && $past(horizontal_cursor_coordinate_o) == '0)
    else $error("readout not blank");
  a_delta_dual: assert property ($rose(second_cursor_on_o)
    |-> ##[0:2] readout_delta_o && readout_row_o == READOUT_ROW)
    else $error("no delta readout");
  a_horiz_delta: assert property ((second_cursor_on_o && $stable(first_cursor_pos_o)
    && $stable(second_cursor_pos_o))[*5]
    |-> horizontal_cursor_coordinate_o == second_cursor_pos_o - first_cursor_pos_o)
    else $error("wrong relative horizontal");
  a_span_mode: assert property (measure_start_o
    |-> span_first_o == (first_cursor_on_o ? $past(first_cursor_pos_o) : FIRST_POINT)
    && span_last_o == (second_cursor_on_o ? $past(second_cursor_pos_o) : LAST_POINT))
    else $error("wrong span");
endmodule : waveform_cursor_control_sva

bind waveform_cursor_control waveform_cursor_control_sva #(.HOLD_CYCLES(HOLD_CYCLES),
  .START_CYCLES(START_CYCLES), .MIN_CYCLES(MIN_CYCLES)) u_sva (.clk_i, .reset_i,
  .first_cursor_pos_o, .second_cursor_pos_o, .first_cursor_on_o, .second_cursor_on_o,
  .cursor_limit_warning_o, .readout_row_o, .readout_delta_o,
  .horizontal_cursor_coordinate_o, .measure_start_o, .span_first_o, .span_last_o);

`default_nettype wire

// ==== verif/test_waveform_cursor_control.sv ====
// self-checking bench for the waveform cursor control block
`timescale 1ns/1ps
`default_nettype none

module test_waveform_cursor_control;
  import cursor_pkg::*;
  // ----------------------------------------
  // signals, keypad and design
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [KEY_N-1:0] k;
  logic [PT_W-1:0] ad, c1, c2, hc, sf, sl, p1 = '0, p2 = '0;
  logic signed [SAMPLE_W-1:0] mem [512];
  logic signed [SAMPLE_W-1:0] vertical_zero_reference = '0, trc = '0, gnd;
  logic signed [COORD_W-1:0] vc;
  logic on1, on2, wrn, dlt, mst, mkd, e1 = 1'b0, e2 = 1'b0, free = 1'b0;
  logic [3:0] row;
  logic [17:0] last;
  logic [17:0] pos_q[$], warn_q[$];
  logic [19:0] meas_q[$];
  int bad_count = 0, cmp_count = 0, cyc = 0, nstep = 0, t0 = 0, g1 = 0, g2 = 0, gl = 0, n;

  keypad_model kb (.clk_i(clk_i), .keys_o(k));
  waveform_cursor_control #(.HOLD_CYCLES(20), .START_CYCLES(8), .MIN_CYCLES(2)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .first_cursor_step_right_i(k[K_C1_RIGHT]),
    .first_cursor_step_left_i(k[K_C1_LEFT]), .second_cursor_step_right_i(k[K_C2_RIGHT]),
    .second_cursor_step_left_i(k[K_C2_LEFT]), .first_cursor_enable_i(k[K_C1_ON]),
    .dual_cursor_enable_i(k[K_DUAL]), .cursors_off_i(k[K_OFF]), .ground_set_i(k[K_GROUND]),
    .amplitude_measure_i(k[K_AMP]), .time_measure_i(k[K_TIME]), .sample_addr_o(ad),
    .sample_data_i(mem[ad]), .vertical_zero_reference_i(vertical_zero_reference), .trace_level_i(trc),
    .first_cursor_pos_o(c1), .second_cursor_pos_o(c2), .first_cursor_on_o(on1),
    .second_cursor_on_o(on2), .cursor_limit_warning_o(wrn), .readout_row_o(row),
    .readout_delta_o(dlt), .vertical_cursor_coordinate_o(vc),
    .horizontal_cursor_coordinate_o(hc), .measure_start_o(mst), .measure_kind_o(mkd),
    .span_first_o(sf), .span_last_o(sl), .ground_ref_o(gnd));

  task automatic chk(input logic [19:0] g, e, input string w);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, w, g, e);
    end
  endtask : chk

  task automatic end_of_test();
    chk(pos_q.size() + warn_q.size() + meas_q.size(), 0, "pending");
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic tap(input int s);
    kb.press(s, 3);
    repeat (10) @(posedge clk_i);
    #1;
  endtask : tap

  // step key with its expected position and warning
  task automatic stp(input int s);
    logic [17:0] o;
    logic act;
    o = {p1, p2};
    act = (s <= K_C1_LEFT) ? e1 : e2;
    if (act && s == K_C1_RIGHT && p1 != LAST_POINT)
      p1 = p1 + 9'h001;
    if (act && s == K_C1_LEFT && p1 != FIRST_POINT)
      p1 = p1 - 9'h001;
    if (act && s == K_C2_RIGHT && p2 != GRAT_RIGHT)
      p2 = p2 + 9'h001;
    if (act && s == K_C2_LEFT && p2 != p1)
      p2 = p2 - 9'h001;
    if (p2 < p1)
      p2 = p1;
    if ({p1, p2} != o)
      pos_q.push_back({p1, p2});
    if (act && (s == K_C1_RIGHT ? p1 == LAST_POINT : s == K_C1_LEFT ? p1 == FIRST_POINT :
        s == K_C2_RIGHT ? p2 == GRAT_RIGHT : p2 == p1))
      warn_q.push_back({p1, p2});
    tap(s);
  endtask : stp

  task automatic mode(input int s);
    e2 = (s == K_DUAL) | (e2 & (s != K_OFF));
    e1 = (s != K_OFF);
    tap(s);
  endtask : mode

  task automatic meas(input int s);
    meas_q.push_back({s == K_TIME, e1 ? p1 : FIRST_POINT, e2 ? p2 : LAST_POINT});
    tap(s);
  endtask : meas

  task automatic ro();
    logic signed [COORD_W-1:0] ev;
    ev = '0;
    if (e1)
      ev = mem[p1] - vertical_zero_reference;
    if (e2)
      ev = mem[p2] - mem[p1];
    chk({row, dlt, hc}, {(e1 | e2) ? READOUT_ROW : ROW_BLANK, e2,
      e2 ? p2 - p1 : e1 ? p1 : FIRST_POINT}, "readout");
    chk(vc, ev, "vertical");
  endtask : ro

  initial
    forever #4 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 15000)
    begin
      chk(0, 1, "timeout");
      end_of_test();
    end
  end

  // ----------------------------------------
  // result watcher, oldest note first
  // ----------------------------------------
  always @(negedge clk_i)
  begin
    if (!reset_i && {c1, c2} !== last)
    begin
      if (free)
      begin
        if (nstep == 1)
          g1 = cyc - t0;
        if (nstep == 2)
          g2 = cyc - t0;
        gl = cyc - t0;
        t0 = cyc;
        nstep++;
      end
      else
        chk({c1, c2}, pos_q.size() ? pos_q.pop_front() : 'x, "pos");
    end
    if (!reset_i && wrn && !free)
      chk({c1, c2}, warn_q.size() ? warn_q.pop_front() : 'x, "warn");
    if (!reset_i && mst)
      chk({mkd, sf, sl}, meas_q.size() ? meas_q.pop_front() : 'x, "span");
    last = {c1, c2};
  end

  initial
  begin
    void'($urandom(98));
    foreach (mem[i])
      mem[i] = SAMPLE_W'($urandom);
    vertical_zero_reference = SAMPLE_W'($urandom);
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk(sl, LAST_POINT, "reset");
    ro();
    stp(K_C1_RIGHT);
    mode(K_C1_ON);
    ro();
    meas(K_AMP);
    stp(K_C1_RIGHT);
    ro();
    stp(K_C1_LEFT);
    stp(K_C1_LEFT);
    free = 1'b1;
    kb.press(K_C1_RIGHT, 100);
    repeat (5) @(posedge clk_i);
    n = nstep;
    repeat (40) @(posedge clk_i);
    chk(nstep, n, "release");
    chk({n > 2, gl < g1}, 2'b11, "repeat");
    chk(g1, 20, "hold delay");
    chk(g2, 8, "first repeat");
    chk(gl, 2, "repeat floor");
    kb.press(K_C1_RIGHT, 4500);
    repeat (10) @(posedge clk_i);
    #1 free = 1'b0;
    p1 = LAST_POINT;
    p2 = LAST_POINT;
    chk({c1, c2}, {p1, p2}, "clamp");
    stp(K_C1_LEFT);
    stp(K_C1_RIGHT);
    stp(K_C1_RIGHT);
    mode(K_OFF);
    ro();
    meas(K_TIME);
    mode(K_DUAL);
    ro();
    stp(K_C2_RIGHT);
    repeat (3) stp(K_C1_LEFT);
    repeat (5)
    begin
      stp(K_C2_LEFT);
      ro();
    end
    stp(K_C1_RIGHT);
    stp(K_C2_RIGHT);
    meas(K_AMP);
    trc = SAMPLE_W'($urandom);
    tap(K_GROUND);
    chk(gnd, trc, "ground");
    repeat (30) stp(K_C1_RIGHT + $urandom_range(3));
    mode(K_OFF);
    mode(K_C1_ON);
    ro();
    end_of_test();
  end
endmodule : test_waveform_cursor_control

`default_nettype wire
